// ===== logic/fpm_button_ctrl.sv
// Purpose: Front-panel button, display mode and long-press control
// Assumes: APB slave, one access cycle; inputs synchronous to clock
// Notes:   Long times are top parameters so a bench can shorten them
`timescale 1ns/10ps
module fpm_button_ctrl #(
    parameter int unsigned NPORT         = fpm_pkg::NPORT_DEF,
    parameter int unsigned NSUP          = fpm_pkg::NSUP_DEF,
    parameter int unsigned TICK_CYCLES   = fpm_pkg::TICK_CYCLES,
    parameter int unsigned IDLE_MS       = fpm_pkg::IDLE_MS,
    parameter int unsigned RST_HOLD_MS   = fpm_pkg::RST_HOLD_MS,
    parameter int unsigned RST_FLASH_MS  = fpm_pkg::RST_FLASH_MS,
    parameter int unsigned MASK_HOLD_MS  = fpm_pkg::MASK_HOLD_MS,
    parameter int unsigned MASK_FLASH_MS = fpm_pkg::MASK_FLASH_MS,
    parameter int unsigned DEBOUNCE_MS   = fpm_pkg::DEBOUNCE_MS,
    parameter int unsigned STEP_MS       = fpm_pkg::STEP_MS
) (
    input  wire logic                      core_clk_i,
    input  wire logic                      arst_n_i,
    input  wire logic                      psel_i,
    input  wire logic                      penable_i,
    input  wire logic                      pwrite_i,
    input  wire logic [fpm_pkg::APB_AW-1:0] paddr_i,
    input  wire logic [31:0]               pwdata_i,
    output logic      [31:0]               prdata_o,
    output logic                           pready_o,
    output logic                           pslverr_o,
    input  wire logic                      button_i,
    input  wire logic                      startup_done_i,
    input  wire logic [NPORT-1:0]          port_link_i,
    input  wire logic [NSUP-1:0]           supply_ok_i,
    input  wire logic [NPORT-1:0]          port_led_normal_i,
    output logic                           mode_indicator_led_first_o,
    output logic                           mode_indicator_led_second_o,
    output logic      [NPORT-1:0]          port_led_o,
    output logic                           fault_o,
    output logic                           factory_reset_o
);
    import fpm_pkg::*;

    localparam int unsigned CW   = NPORT + NSUP;
    localparam int unsigned WW   = $clog2(NPORT);
    localparam int unsigned SW   = $clog2(STEP_MS);
    localparam logic [CW-1:0] MASK_RST = '0;

    function automatic fpm_mode_t next_mode(input fpm_mode_t m);
        case (m)
            MODE_A:  next_mode = MODE_B;
            MODE_B:  next_mode = MODE_C;
            MODE_C:  next_mode = MODE_D;
            MODE_D:  next_mode = MODE_A;
            default: next_mode = MODE_A;
        endcase
    endfunction

    function automatic logic [1:0] mode_leds(input fpm_mode_t m);
        case (m)
            MODE_A:  mode_leds = 2'h0;
            MODE_B:  mode_leds = 2'h1;
            MODE_C:  mode_leds = 2'h2;
            MODE_D:  mode_leds = 2'h3;
            default: mode_leds = 2'h0;
        endcase
    endfunction

    logic              tick_w;
    logic              btn_w;
    logic              btn_q_reg;
    fpm_mode_t         mode_reg;
    fpm_mode_t         mode_next;
    fpm_hold_t         kind_reg;
    fpm_hold_t         kind_next;
    logic [MS_W-1:0]   hold_reg;
    logic [MS_W-1:0]   hold_next;
    logic [MS_W-1:0]   idle_reg;
    logic [MS_W-1:0]   idle_next;
    logic              spent_reg;
    logic [SW-1:0]     step_reg;
    logic [WW-1:0]     walk_reg;
    logic              blink_reg;
    logic              ctrl_reg;
    logic [CW-1:0]     mask_reg;
    logic [CW-1:0]     mask_next;
    logic [CW-1:0]     cond_w;
    logic              press_w;
    logic              rel_w;
    logic              rst_ok_w;
    logic              armed_w;
    logic [MS_W-1:0]   done_ms_w;
    logic [MS_W-1:0]   flash_ms_w;
    logic              fire_w;
    logic              fire_rst_w;
    logic              fire_mask_w;
    logic              flash_w;
    logic              idle_out_w;
    logic              step_end_w;
    logic [1:0]        led_next;
    logic [NPORT-1:0]  port_next;
    logic              setup_w;
    logic              wr_w;
    logic              hit_w;
    logic [31:0]       rdata_w;
    logic [31:0]       status_w;

    fpm_tick_div #(
        .DIV (TICK_CYCLES)
    ) u_tick (
        .core_clk_i (core_clk_i),
        .arst_n_i   (arst_n_i),
        .tick_o     (tick_w)
    );

    fpm_debounce #(
        .CNT (DEBOUNCE_MS)
    ) u_deb (
        .core_clk_i (core_clk_i),
        .arst_n_i   (arst_n_i),
        .tick_i     (tick_w),
        .raw_i      (button_i),
        .level_o    (btn_w)
    );

    // Edges of the debounced button
    assign press_w = btn_w & ~btn_q_reg;
    assign rel_w   = ~btn_w & btn_q_reg;

    // Disable bit ignored until startup done
    assign rst_ok_w = ctrl_reg | ~startup_done_i;

    // Kind of long press is fixed when the press starts
    assign kind_next = !press_w ? kind_reg :
        (mode_reg == MODE_A && rst_ok_w) ? HOLD_RESET :
        (mode_reg == MODE_D) ? HOLD_MASK : HOLD_NONE;

    assign done_ms_w  = (kind_reg == HOLD_RESET) ? MS_W'(RST_HOLD_MS)
                                                 : MS_W'(MASK_HOLD_MS);
    assign flash_ms_w = (kind_reg == HOLD_RESET) ? MS_W'(RST_FLASH_MS)
                                                 : MS_W'(MASK_FLASH_MS);

    // Press cycle excluded: kind and hold still belong to the last press
    assign armed_w = btn_w & ~press_w & ~spent_reg
                   & (kind_reg != HOLD_NONE);
    assign fire_w      = armed_w & (hold_reg >= done_ms_w);
    assign fire_rst_w  = fire_w & (kind_reg == HOLD_RESET);
    assign fire_mask_w = fire_w & (kind_reg == HOLD_MASK);
    assign flash_w     = armed_w & (hold_reg >= flash_ms_w);

    // Hold timer: zero on press, counts only while held
    assign hold_next = press_w ? '0 :
        (btn_w && tick_w && hold_reg != '1) ? hold_reg + 1'b1 : hold_reg;

    assign idle_out_w = (idle_reg >= MS_W'(IDLE_MS)) & ~btn_w;
    assign idle_next  = btn_w ? '0 :
        (tick_w && !idle_out_w) ? idle_reg + 1'b1 : idle_reg;

    // Factory reset wins over every other mode change
    assign mode_next = fire_rst_w ? MODE_A :
        (rel_w && !spent_reg) ? next_mode(mode_reg) :
        idle_out_w ? MODE_A : mode_reg;

    assign cond_w    = {supply_ok_i, port_link_i};
    assign mask_next = fire_rst_w ? MASK_RST :
        fire_mask_w ? cond_w : mask_reg;

    assign step_end_w = tick_w & (step_reg == SW'(STEP_MS - 1));

    assign led_next = flash_w ? {blink_reg, blink_reg}
                              : mode_leds(mode_reg);

    // Normal port indication is owned by the caller
    assign port_next = flash_w ? NPORT'(1) << walk_reg
                               : port_led_normal_i;

    // APB decode; data captured in setup, answered in access
    assign setup_w = psel_i & ~penable_i;
    assign wr_w    = psel_i & penable_i & pready_o & pwrite_i;
    assign hit_w   = (paddr_i == CTRL_OFS) | (paddr_i == STATUS_OFS)
                   | (paddr_i == MASK_OFS) | (paddr_i == COND_OFS)
                   | (paddr_i == HOLD_OFS);

    assign status_w = 32'(mode_reg) << ST_MODE_LSB
                    | 32'(btn_w) << ST_PRESSED_BIT
                    | 32'(flash_w) << ST_FLASH_BIT
                    | 32'(fault_o) << ST_FAULT_BIT
                    | 32'(startup_done_i) << ST_STARTUP_BIT;

    assign rdata_w =
        (paddr_i == CTRL_OFS)   ? 32'(ctrl_reg) << CTRL_RST_EN_BIT :
        (paddr_i == STATUS_OFS) ? status_w :
        (paddr_i == MASK_OFS)   ? 32'(mask_reg) :
        (paddr_i == COND_OFS)   ? 32'(cond_w) :
        (paddr_i == HOLD_OFS)   ? 32'(hold_reg) : 32'h0000_0000;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= setup_w;
            pslverr_o <= setup_w & ~hit_w;
            prdata_o  <= (setup_w && !pwrite_i) ? rdata_w : prdata_o;
        end
    end

    // Factory default wins over a write in the same cycle
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_reg <= CTRL_RST;
        end else if (fire_rst_w) begin
            ctrl_reg <= CTRL_RST;
        end else if (wr_w && paddr_i == CTRL_OFS) begin
            ctrl_reg <= pwdata_i[CTRL_RST_EN_BIT];
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            btn_q_reg <= 1'b0;
            mode_reg  <= MODE_A;
            kind_reg  <= HOLD_NONE;
            hold_reg  <= '0;
            idle_reg  <= '0;
            spent_reg <= 1'b0;
            mask_reg  <= MASK_RST;
        end else begin
            btn_q_reg <= btn_w;
            mode_reg  <= mode_next;
            kind_reg  <= kind_next;
            hold_reg  <= hold_next;
            idle_reg  <= idle_next;
            spent_reg <= press_w ? 1'b0 : (spent_reg | fire_w);
            mask_reg  <= mask_next;
        end
    end

    // Flash and walk restart on every warning so each run looks alike
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            step_reg  <= '0;
            walk_reg  <= '0;
            blink_reg <= 1'b1;
        end else if (!flash_w) begin
            step_reg  <= '0;
            walk_reg  <= '0;
            blink_reg <= 1'b1;
        end else if (step_end_w) begin
            step_reg  <= '0;
            blink_reg <= ~blink_reg;
            walk_reg  <= (walk_reg == WW'(NPORT - 1)) ? '0
                                                      : walk_reg + 1'b1;
        end else if (tick_w) begin
            step_reg  <= step_reg + 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_indicator_led_first_o  <= 1'b0;
            mode_indicator_led_second_o <= 1'b0;
            port_led_o                  <= '0;
            fault_o                     <= 1'b0;
            factory_reset_o             <= 1'b0;
        end else begin
            mode_indicator_led_first_o  <= led_next[0];
            mode_indicator_led_second_o <= led_next[1];
            port_led_o                  <= port_next;
            fault_o                     <= (cond_w != mask_reg);
            factory_reset_o             <= fire_rst_w;
        end
    end

    property p_mode_a_dark;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (mode_reg == MODE_A && !flash_w) |=>
            !mode_indicator_led_first_o && !mode_indicator_led_second_o;
    endproperty
    a_mode_a_dark: assert property (p_mode_a_dark)
        else $error("mode A LEDs not dark");

    property p_mode_d_green;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (mode_reg == MODE_D && !flash_w) |=>
            mode_indicator_led_first_o && mode_indicator_led_second_o;
    endproperty
    a_mode_d_green: assert property (p_mode_d_green)
        else $error("mode D LEDs not both lit");

    property p_mode_bc;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (mode_reg inside {MODE_B, MODE_C} && !flash_w) |=>
            (mode_indicator_led_first_o != mode_indicator_led_second_o)
            && (mode_indicator_led_first_o == ($past(mode_reg) == MODE_B));
    endproperty
    a_mode_bc: assert property (p_mode_bc)
        else $error("mode B or C LED pattern wrong");

    property p_advance;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (rel_w && !spent_reg) |=> mode_reg == next_mode($past(mode_reg));
    endproperty
    a_advance: assert property (p_advance)
        else $error("short press did not advance mode");

    property p_reset_pulse;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        fire_rst_w |=> factory_reset_o && mode_reg == MODE_A
            && ctrl_reg == CTRL_RST ##1 !factory_reset_o;
    endproperty
    a_reset_pulse: assert property (p_reset_pulse)
        else $error("factory reset not a one-cycle pulse");

    property p_reset_needs_hold;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        $rose(factory_reset_o) |->
            $past(btn_w) && $past(hold_reg) >= MS_W'(RST_HOLD_MS);
    endproperty
    a_reset_needs_hold: assert property (p_reset_needs_hold)
        else $error("factory reset without full hold");

    property p_mask_change;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (mask_reg != $past(mask_reg)) |->
            $past(fire_mask_w) || $past(fire_rst_w);
    endproperty
    a_mask_change: assert property (p_mask_change)
        else $error("fault mask changed without completed hold");

    property p_fault;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        ##1 1'b1 |-> fault_o == ($past(cond_w) != $past(mask_reg));
    endproperty
    a_fault: assert property (p_fault)
        else $error("fault output disagrees with mask");

    property p_startup_reset;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (press_w && mode_reg == MODE_A && !startup_done_i) |=>
            kind_reg == HOLD_RESET;
    endproperty
    a_startup_reset: assert property (p_startup_reset)
        else $error("reset hold not honoured during startup");

    property p_hold_restart;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        press_w |=> hold_reg == '0;
    endproperty
    a_hold_restart: assert property (p_hold_restart)
        else $error("hold timer not restarted on press");

    property p_idle_back;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (idle_out_w && !rel_w) |=> mode_reg == MODE_A;
    endproperty
    a_idle_back: assert property (p_idle_back)
        else $error("idle timeout did not return to mode A");

endmodule

// ===== logic/fpm_pkg.sv
// Purpose: Shared constants for the front-panel button and mode block
// Assumes: 10 MHz core clock, millisecond tick as the slow time base
// Notes:   Times kept in their own unit; tick counts derived below
package fpm_pkg;

    // Clock and time base
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned TICK_NS       = 1000000;
    localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
    localparam int unsigned MS_PER_S      = 1000;

    // Operator timing, in seconds as printed
    localparam int unsigned IDLE_TIME_S      = 60;
    localparam int unsigned RST_HOLD_S       = 12;
    localparam int unsigned RST_FLASH_S      = 9;
    localparam int unsigned MASK_HOLD_S      = 5;
    localparam int unsigned MASK_FLASH_S     = 2;

    // Derived tick counts
    localparam int unsigned IDLE_MS       = IDLE_TIME_S * MS_PER_S;
    localparam int unsigned RST_HOLD_MS   = RST_HOLD_S * MS_PER_S;
    localparam int unsigned RST_FLASH_MS  = RST_FLASH_S * MS_PER_S;
    localparam int unsigned MASK_HOLD_MS  = MASK_HOLD_S * MS_PER_S;
    localparam int unsigned MASK_FLASH_MS = MASK_FLASH_S * MS_PER_S;
    localparam int unsigned DEBOUNCE_MS   = 20;
    localparam int unsigned STEP_MS       = 250;
    localparam int unsigned MS_W          = 17;

    // Sizes
    localparam int unsigned NPORT_DEF = 8;
    localparam int unsigned NSUP_DEF  = 2;
    localparam int unsigned APB_AW    = 8;

    // Register map, byte addresses
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] MASK_OFS   = 8'h08;
    localparam logic [7:0] COND_OFS   = 8'h0c;
    localparam logic [7:0] HOLD_OFS   = 8'h10;

    // Field positions and reset values
    localparam int unsigned CTRL_RST_EN_BIT = 0;
    localparam logic        CTRL_RST        = 1'h1;
    localparam int unsigned ST_MODE_LSB     = 0;
    localparam int unsigned ST_PRESSED_BIT  = 2;
    localparam int unsigned ST_FLASH_BIT    = 3;
    localparam int unsigned ST_FAULT_BIT    = 4;
    localparam int unsigned ST_STARTUP_BIT  = 5;

    typedef enum logic [1:0] {
        MODE_A,
        MODE_B,
        MODE_C,
        MODE_D
    } fpm_mode_t;

    typedef enum logic [1:0] {
        HOLD_NONE,
        HOLD_RESET,
        HOLD_MASK
    } fpm_hold_t;

endpackage

// ===== logic/fpm_tick_div.sv
// Purpose: One-cycle enable pulse every DIV core clocks
// Assumes: Single clock domain
// Notes:   Output pulse comes from a flip-flop
`timescale 1ns/10ps
module fpm_tick_div #(
    parameter int unsigned DIV = fpm_pkg::TICK_CYCLES
) (
    input  wire logic core_clk_i,
    input  wire logic arst_n_i,
    output logic      tick_o
);
    import fpm_pkg::*;

    localparam int unsigned CW = $clog2(DIV);

    logic [CW-1:0] cnt_reg;
    logic          last_w;

    assign last_w = (cnt_reg == CW'(DIV - 1));

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_reg <= '0;
            tick_o  <= 1'b0;
        end else begin
            cnt_reg <= last_w ? '0 : cnt_reg + 1'b1;
            tick_o  <= last_w;
        end
    end

endmodule

// ===== logic/fpm_debounce.sv
// Purpose: Button debouncer on the millisecond tick
// Assumes: Raw input already synchronous to core_clk_i
// Notes:   Level must stay changed for CNT ticks before it is taken
`timescale 1ns/10ps
module fpm_debounce #(
    parameter int unsigned CNT = fpm_pkg::DEBOUNCE_MS
) (
    input  wire logic core_clk_i,
    input  wire logic arst_n_i,
    input  wire logic tick_i,
    input  wire logic raw_i,
    output logic      level_o
);
    import fpm_pkg::*;

    localparam int unsigned CW = $clog2(CNT + 1);

    logic [CW-1:0] cnt_reg;
    logic          diff_w;

    assign diff_w = (raw_i != level_o);

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_reg <= '0;
            level_o <= 1'b0;
        end else if (!diff_w) begin
            cnt_reg <= '0;
        end else if (tick_i) begin
            if (cnt_reg == CW'(CNT - 1)) begin
                cnt_reg <= '0;
                level_o <= raw_i;
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

endmodule

// ===== tb/fpm_operator.sv
// Purpose: Operator pressing the front-panel button
// Assumes: Tasks are called just after a rising clock edge
// Notes:   Contact bounces once on every press, as real switches do
`timescale 1ns/10ps
module fpm_operator (
    input  wire logic core_clk_i,
    output logic      button_o
);
    initial button_o = 1'b0;

    task automatic push();
        button_o <= 1'b1;
        @(posedge core_clk_i);
        button_o <= 1'b0;
        @(posedge core_clk_i);
        button_o <= 1'b1;
    endtask

    task automatic lift();
        button_o <= 1'b0;
    endtask
endmodule

// ===== tb/tb_front_panel_button_mode_control.sv
// Purpose: Self-checking bench for the button and mode block
// Assumes: 1 ms = 2 clocks; reset and idle times shortened, mask as built
// Notes:   Each scenario starts from display mode A
`timescale 1ns/10ps
module tb_front_panel_button_mode_control;
    import fpm_pkg::*;
    localparam int TK = 2;
    logic        core_clk_i, arst_n_i, psel_i, penable_i, pwrite_i;
    logic [7:0]  paddr_i, port_link_i, port_led_o, port_led_normal_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic        pready_o, pslverr_o, button_i, startup_done_i, err;
    logic [1:0]  supply_ok_i;
    logic        led1, led2, fault_o, factory_reset_o;
    int          errors, cmp_count, pulses;

    fpm_button_ctrl #(.TICK_CYCLES(TK), .DEBOUNCE_MS(2), .IDLE_MS(200),
        .RST_FLASH_MS(30), .RST_HOLD_MS(40)) u_fpm_button_ctrl (
        .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .button_i(button_i),
        .startup_done_i(startup_done_i), .port_link_i(port_link_i),
        .supply_ok_i(supply_ok_i), .port_led_normal_i(port_led_normal_i),
        .mode_indicator_led_first_o(led1),
        .mode_indicator_led_second_o(led2), .port_led_o(port_led_o),
        .fault_o(fault_o), .factory_reset_o(factory_reset_o));

    fpm_operator u_fpm_operator (.core_clk_i(core_clk_i),
        .button_o(button_i));

    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    always @(posedge core_clk_i) begin
        if (factory_reset_o === 1'b1) pulses++;
    end

    task automatic end_of_test();
        if (errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic ms(input int n);
        repeat (n * TK) @(posedge core_clk_i);
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel_i   <= 1'b1;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge core_clk_i);
            if (pready_o === 1'b1) break;
        end
        if (n == 16) begin
            errors++;
            end_of_test();
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        @(posedge core_clk_i);
    endtask

    task automatic press(input int n);
        u_fpm_operator.push();
        ms(n);
        u_fpm_operator.lift();
        ms(5);
    endtask

    // Flash keeps both LEDs together, port LEDs walk one at a time
    task automatic chk_flash(input logic [1:0] leds,
                             input logic [7:0] walk);
        chk({30'h0, led1, led2}, {30'h0, leds}, "flash leds");
        chk({24'h0, port_led_o}, {24'h0, walk}, "port walk");
    endtask

    task automatic t_regs();
        apb(1'b0, CTRL_OFS, 32'h0);
        chk(rd, 32'h1, "ctrl reset");
        apb(1'b0, STATUS_OFS, 32'h0);
        chk(rd & 32'h3, 32'h0, "default mode");
        apb(1'b1, MASK_OFS, 32'h3ff);
        apb(1'b0, MASK_OFS, 32'h0);
        chk(rd, 32'h0, "mask read-only");
        apb(1'b0, 8'h14, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        chk({31'h0, fault_o}, 32'h1, "fault vs empty mask");
    endtask

    task automatic t_modes();
        logic [1:0] exp [4] = '{2'b00, 2'b10, 2'b01, 2'b11};
        for (int i = 1; i < 5; i++) begin
            press(6);
            chk({led1, led2}, exp[i % 4], "mode leds");
        end
    endtask

    task automatic t_idle();
        press(6);
        ms(150);
        chk({led1, led2}, 2'b10, "early idle");
        ms(60);
        chk({led1, led2}, 2'b00, "idle return");
    endtask

    // Mask hold runs at full length; walk steps every 250 ms
    task automatic t_mask();
        repeat (3) press(6);
        port_link_i <= 8'ha5;
        supply_ok_i <= 2'b10;
        u_fpm_operator.push();
        ms(2100);
        chk_flash(2'b11, 8'h01);
        ms(250);
        chk_flash(2'b00, 8'h02);
        ms(3000);
        u_fpm_operator.lift();
        ms(5);
        apb(1'b0, MASK_OFS, 32'h0);
        chk(rd, 32'h2a5, "mask stored");
        chk({led1, led2}, 2'b11, "no advance");
        chk({31'h0, fault_o}, 32'h0, "no fault");
        port_link_i <= 8'ha4;
        port_led_normal_i <= 8'hc3;
        ms(1);
        chk({31'h0, fault_o}, 32'h1, "fault");
        chk(port_led_o, 8'hc3, "normal port leds");
        press(4000);
        apb(1'b0, MASK_OFS, 32'h0);
        chk(rd, 32'h2a5, "mask kept");
    endtask

    task automatic t_reset();
        int p0;
        ms(210);
        apb(1'b1, CTRL_OFS, 32'h0);
        p0 = pulses;
        press(45);
        chk(pulses, p0, "disabled reset");
        ms(210);
        startup_done_i <= 1'b0;
        u_fpm_operator.push();
        ms(35);
        chk_flash(2'b11, 8'h01);
        u_fpm_operator.lift();
        ms(5);
        chk(pulses, p0, "cancelled reset");
        ms(210);
        press(45);
        chk(pulses, p0 + 1, "reset pulse");
        apb(1'b0, CTRL_OFS, 32'h0);
        chk(rd, 32'h1, "ctrl default");
        apb(1'b0, MASK_OFS, 32'h0);
        chk(rd, 32'h0, "mask default");
        chk({led1, led2}, 2'b00, "mode A");
        startup_done_i <= 1'b1;
        press(45);
        chk(pulses, p0 + 2, "enabled reset");
    endtask

    initial begin
        #(100 * 40000);
        errors++;
        end_of_test();
    end

    initial begin
        {errors, cmp_count, pulses} = '0;
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        arst_n_i = 1'b0;
        startup_done_i = 1'b1;
        port_link_i = 8'h0f;
        supply_ok_i = 2'b01;
        port_led_normal_i = 8'h3c;
        repeat (4) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        @(posedge core_clk_i);
        t_regs();
        t_modes();
        t_idle();
        t_mask();
        t_reset();
        end_of_test();
    end
endmodule
